// File: include/ptm_pkg.sv
// Purpose: Constants for the periodic timer block
// Assumes: AXI4-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses
package ptm_pkg;
  localparam logic [7:0] CTRL0_OFF    = 8'h00;
  localparam logic [7:0] CTRL1_OFF    = 8'h04;
  localparam logic [7:0] CNT_LO_OFF   = 8'h08;
  localparam logic [7:0] CNT_HI_OFF   = 8'h0C;
  localparam logic [7:0] CMPA_LO_OFF  = 8'h10;
  localparam logic [7:0] CMPA_HI_OFF  = 8'h14;
  localparam logic [7:0] PER_LO_OFF   = 8'h18;
  localparam logic [7:0] PER_HI_OFF   = 8'h1C;
  localparam logic [7:0] FLAGS_OFF    = 8'h20;
  // Control 0 fields
  localparam int PAUSE_BIT  = 7;
  localparam int CKSEL_LSB  = 4;
  localparam int RUN_BIT    = 3;
  // Control 1 fields
  localparam int MODE_LSB   = 6;
  localparam int PACT_LSB   = 4;
  localparam int INIT_BIT   = 3;
  localparam int INV_BIT    = 2;
  localparam int CLRSEL_BIT = 0;
  // Flag register fields
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [9:0]  VAL_RST  = 10'h000;
  localparam logic [9:0]  CNT_MAX  = 10'h3FF;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [1:0]  MODE_CMP = 2'b00;
  localparam logic [1:0]  MODE_PWM = 2'b10;
  localparam logic [1:0]  MODE_TC  = 2'b11;
  localparam logic [1:0]  PACT_NONE = 2'b00;
  localparam logic [1:0]  PACT_LOW  = 2'b01;
  localparam logic [1:0]  PACT_HIGH = 2'b10;
  localparam logic [1:0]  PACT_TOG  = 2'b11;
  localparam logic [2:0]  CK_SYS4   = 3'h0;
  localparam logic [2:0]  CK_SYS    = 3'h1;
  localparam logic [2:0]  CK_H16    = 3'h2;
  localparam logic [2:0]  CK_H64    = 3'h3;
  localparam logic [2:0]  CK_EXTR   = 3'h6;
  localparam logic [2:0]  CK_EXTF   = 3'h7;
  localparam logic [5:0]  DIV4_MASK  = 6'h03;
  localparam logic [5:0]  DIV16_MASK = 6'h0F;
  localparam logic [5:0]  DIV64_MASK = 6'h3F;
endpackage : ptm_pkg

// File: rtl/ptm_timer.sv
// Purpose: 10-bit periodic timer with comparators A and P, AXI4-Lite registers
// Assumes: CORE_CLK is the system clock; high and sub clocks arrive as inputs
// Notes:   Counter ticks are one-cycle enables made from the selected source
`timescale 1ns/10ps
// Functional notes
// - Counter readable as low byte and high byte bits 9..8, rest zero.
// - Comparator A value read/write, high byte holds bits 9..8 only.
// - Comparator P value read/write, high byte holds bits 9..8 only.
// - Mode 00 compare, 11 timer, 10 PWM, 10 with action 11 single pulse.
// - Clear-select low: clear on P match or overflow when P zero; both flags.
// - Clear-select high: clear on A match, only A flag raised.
// - A value zero: no A flag; with clear-select high, counter overflows at 3FF.
// - Compare mode: after run rise, pin changes only on A flag, per pin action field.
// - Compare mode: run rising edge loads pin with initial level.
// - Timer mode behaves as compare mode but leaves pin undriven.
// - PWM ignores clear-select; P gives period, zero means 1024; A duty.
// - PWM raises A flag and P flag on their matches.
// - PWM duty at or above period gives full active output.
// - PWM counting and flags continue while pin forced inactive or active.
// - PWM active level from initial bit, output inverted by invert bit.
// - Single pulse starts on run rise, software or external clock edge.
// - Pulse ends on run clear or A match; A match clears run, flags.
// - Single pulse clears counter only on run rise, ignores P and clear-select.
// - Run rise zeroes counter; run fall holds residual count.
// - Three-bit clock select: sys/4, sys, high/16, high/64, sub, ext edges.
// - Pause freezes counter; clearing pause resumes from held value.
module ptm_timer
  import ptm_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        HIGH_CLK_TICK,
  input  wire logic        SUB_CLK,
  input  wire logic        EXT_CLK_PIN,
  output logic             TIMER_OUT,
  output logic             TIMER_OUT_EN,
  output logic             MATCH_A_FLAG,
  output logic             MATCH_P_FLAG,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cmpa_q;
  logic [9:0] per_q;
  logic [9:0] cnt_q;
  logic       flag_a_q;
  logic       flag_p_q;
  logic       pin_q;
  logic       run_prev_q;

  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       aw_full_q;
  logic       w_full_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == CTRL0_OFF) || (a == CTRL1_OFF) || (a == CNT_LO_OFF) ||
                 (a == CNT_HI_OFF) || (a == CMPA_LO_OFF) || (a == CMPA_HI_OFF) ||
                 (a == PER_LO_OFF) || (a == PER_HI_OFF) || (a == FLAGS_OFF);
  endfunction : known_addr

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  logic do_write;
  logic wr_ok;
  logic [7:0] wbyte;
  assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_full_q && !bvalid_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ok         = known_addr(aw_addr_q);
  assign wbyte         = w_strb_q[0] ? w_data_q[7:0] : 8'h00;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;

  logic sw_wr_ctrl0;
  logic sw_wr_ctrl1;
  assign sw_wr_ctrl0 = do_write && w_strb_q[0] && (aw_addr_q == CTRL0_OFF);
  assign sw_wr_ctrl1 = do_write && w_strb_q[0] && (aw_addr_q == CTRL1_OFF);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmpa_q <= VAL_RST;
      per_q  <= VAL_RST;
    end else if (do_write && w_strb_q[0]) begin
      unique case (aw_addr_q)
        CMPA_LO_OFF: cmpa_q[7:0] <= wbyte;
        CMPA_HI_OFF: cmpa_q[9:8] <= wbyte[1:0];
        PER_LO_OFF:  per_q[7:0]  <= wbyte;
        PER_HI_OFF:  per_q[9:8]  <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl1_q <= CTRL_RST;
    end else if (sw_wr_ctrl1) begin
      ctrl1_q <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q  <= known_addr(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        CTRL0_OFF:   rdata_q <= {24'h00_0000, ctrl0_q[7:3], 3'b000};
        CTRL1_OFF:   rdata_q <= {24'h00_0000, ctrl1_q};
        CNT_LO_OFF:  rdata_q <= {24'h00_0000, cnt_q[7:0]};
        CNT_HI_OFF:  rdata_q <= {30'h0000_0000, cnt_q[9:8]};
        CMPA_LO_OFF: rdata_q <= {24'h00_0000, cmpa_q[7:0]};
        CMPA_HI_OFF: rdata_q <= {30'h0000_0000, cmpa_q[9:8]};
        PER_LO_OFF:  rdata_q <= {24'h00_0000, per_q[7:0]};
        PER_HI_OFF:  rdata_q <= {30'h0000_0000, per_q[9:8]};
        FLAGS_OFF:   rdata_q <= {30'h0000_0000, flag_p_q, flag_a_q};
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection and external pin synchroniser
  logic [2:0] ext_sync_q;
  logic [1:0] sub_sync_q;
  logic       sub_prev_q;
  logic [5:0] pre_q;
  logic [5:0] hpre_q;
  logic       ext_rise;
  logic       ext_fall;
  logic       tick;
  logic [2:0] cksel;
  assign cksel    = ctrl0_q[CKSEL_LSB +: 3];
  assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];
  assign ext_fall = !ext_sync_q[1] && ext_sync_q[2];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ext_sync_q <= 3'b000;
      sub_sync_q <= 2'b00;
      sub_prev_q <= 1'b0;
      pre_q      <= 6'h00;
      hpre_q     <= 6'h00;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], EXT_CLK_PIN};
      sub_sync_q <= {sub_sync_q[0], SUB_CLK};
      sub_prev_q <= sub_sync_q[1];
      pre_q      <= pre_q + 6'h01;
      if (HIGH_CLK_TICK) begin
        hpre_q <= hpre_q + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (cksel)
      CK_SYS4:  tick = (pre_q & DIV4_MASK) == DIV4_MASK;
      CK_SYS:   tick = 1'b1;
      CK_H16:   tick = HIGH_CLK_TICK && ((hpre_q & DIV16_MASK) == DIV16_MASK);
      CK_H64:   tick = HIGH_CLK_TICK && ((hpre_q & DIV64_MASK) == DIV64_MASK);
      CK_EXTR:  tick = ext_rise;
      CK_EXTF:  tick = ext_fall;
      default:  tick = sub_sync_q[1] && !sub_prev_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and comparators
  logic [1:0] mode;
  logic [1:0] pact;
  logic       is_pwm;
  logic       is_pulse;
  logic       is_cmp_like;
  logic       run;
  logic       run_rise;
  logic       counting;
  logic       match_a;
  logic       match_p;
  logic       overflow;
  logic       clr_cnt;
  logic       ev_a;
  logic       ev_p;
  logic [9:0] per_last;
  logic       ext_trig;

  assign mode        = ctrl1_q[MODE_LSB +: 2];
  assign pact        = ctrl1_q[PACT_LSB +: 2];
  assign is_pwm      = (mode == MODE_PWM) && (pact != PACT_TOG);
  assign is_pulse    = (mode == MODE_PWM) && (pact == PACT_TOG);
  assign is_cmp_like = (mode == MODE_CMP) || (mode == MODE_TC);
  assign run         = ctrl0_q[RUN_BIT];
  assign run_rise    = run && !run_prev_q;
  assign counting    = run && !ctrl0_q[PAUSE_BIT] && tick && !run_rise;
  // Pending increment: compare against the value about to be reached
  assign match_a     = counting && (cmpa_q != VAL_RST) && (cnt_q + 10'h001 == cmpa_q);
  assign per_last    = per_q - 10'h001;
  assign overflow    = counting && (cnt_q == CNT_MAX);
  assign match_p     = counting && ((per_q == VAL_RST) ? overflow
                                                       : (cnt_q + 10'h001 == per_q));
  assign ext_trig    = is_pulse && !run &&
                       ((cksel == CK_EXTF) ? ext_fall : ext_rise);

  always_comb begin
    clr_cnt = 1'b0;
    ev_a    = 1'b0;
    ev_p    = 1'b0;
    if (is_cmp_like) begin
      if (ctrl1_q[CLRSEL_BIT]) begin
        ev_a    = match_a;
        clr_cnt = match_a || (cmpa_q == VAL_RST && overflow);
      end else begin
        ev_a    = match_a;
        ev_p    = match_p;
        clr_cnt = match_p;
      end
    end else if (is_pwm) begin
      ev_a    = match_a;
      ev_p    = match_p;
      clr_cnt = match_p;
    end else if (is_pulse) begin
      ev_a    = match_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control 0 with hardware run set and clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl0_q <= CTRL_RST;
    end else begin
      if (sw_wr_ctrl0) begin
        ctrl0_q <= {wbyte[7:3], 3'b000};
      end
      if (ext_trig) begin
        ctrl0_q[RUN_BIT] <= 1'b1;
      end else if (is_pulse && ev_a) begin
        ctrl0_q[RUN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= VAL_RST;
    end else if (run_rise) begin
      cnt_q <= VAL_RST;
    end else if (counting) begin
      cnt_q <= clr_cnt ? VAL_RST : cnt_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; set beats a software clear in the same cycle
  logic clr_a;
  logic clr_p;
  assign clr_a = do_write && w_strb_q[0] && (aw_addr_q == FLAGS_OFF) && wbyte[FLAG_A_BIT];
  assign clr_p = do_write && w_strb_q[0] && (aw_addr_q == FLAGS_OFF) && wbyte[FLAG_P_BIT];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      flag_a_q <= ev_a || (flag_a_q && !clr_a);
      flag_p_q <= ev_p || (flag_p_q && !clr_p);
    end
  end
  assign MATCH_A_FLAG = flag_a_q;
  assign MATCH_P_FLAG = flag_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output pin
  logic pwm_active;
  logic act_lvl;
  logic pwm_lvl;
  assign act_lvl    = ctrl1_q[INIT_BIT];
  // Duty at or above period keeps the output active all period
  assign pwm_active = (per_q == VAL_RST) ? (cnt_q < cmpa_q)
                    : ((cmpa_q >= per_q) || (cnt_q < cmpa_q));
  always_comb begin
    unique case (pact)
      PACT_NONE: pwm_lvl = !act_lvl;
      PACT_LOW:  pwm_lvl = act_lvl;
      default:   pwm_lvl = run && pwm_active ? act_lvl : !act_lvl;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_q <= 1'b0;
    end else if (mode == MODE_CMP) begin
      if (run_rise) begin
        pin_q <= ctrl1_q[INIT_BIT];
      end else if (ev_a) begin
        unique case (pact)
          PACT_LOW:  pin_q <= 1'b0;
          PACT_HIGH: pin_q <= 1'b1;
          PACT_TOG:  pin_q <= !pin_q;
          default:   pin_q <= pin_q;
        endcase
      end
    end else if (is_pwm) begin
      pin_q <= pwm_lvl;
    end else if (is_pulse) begin
      pin_q <= (run || ext_trig) && !(ev_a) ? act_lvl : !act_lvl;
    end
  end

  // Polarity inversion applies to waveform modes; timer mode releases the pin
  assign TIMER_OUT    = pin_q ^ (ctrl1_q[INV_BIT] && (mode != MODE_TC));
  assign TIMER_OUT_EN = (mode != MODE_TC) && (mode != 2'b01);

  logic unused_ok;
  assign unused_ok = ^{per_last, w_data_q[31:8], w_strb_q[3:1]};

endmodule : ptm_timer

// File: tb/pt_checker.sv
// Purpose: Concurrent checks on the periodic timer register bus and flags
// Assumes: Single CORE_CLK domain, RST asynchronous active high
// Notes:   Bound to the timer top from the bench top file
`timescale 1ns/10ps
module pt_checker
  import ptm_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        MATCH_A_FLAG,
  input wire logic        MATCH_P_FLAG,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_pair;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_ar_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  // Flags only drop through a register write landing
  a_flag_sticky: assert property (($fell(MATCH_A_FLAG) || $fell(MATCH_P_FLAG)) |->
    ($past(S_AXI_WVALID, 1) || $past(S_AXI_WVALID, 2) || $past(S_AXI_WVALID, 3)))
    else $error("flag dropped without a register write");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response not held");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data not held");
  a_r_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_r_latency: assert property (s_ar_take |=> S_AXI_RVALID)
    else $error("read answer late");
  a_b_latency: assert property (s_wr_pair |-> ##[1:4] S_AXI_BVALID)
    else $error("write answer late");
  a_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while answer pending");
  a_w_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  a_bresp_legal: assert property (S_AXI_BVALID |->
    (S_AXI_BRESP == RESP_OKAY || S_AXI_BRESP == RESP_SLVERR)) else $error("bad write response");
  a_slverr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |->
    S_AXI_RDATA == 32'h0000_0000) else $error("unmapped read data not zero");
endmodule : pt_checker

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the periodic timer
// Assumes: CORE_CLK 100 MHz, registers reached over AXI4-Lite
// Notes:   Random register data from a fixed seed, corner cases by table
`timescale 1ns/10ps
module tb_top;
  import ptm_pkg::*;
  logic        CORE_CLK, RST, HIGH_CLK_TICK, SUB_CLK, EXT_CLK_PIN;
  logic        TIMER_OUT, TIMER_OUT_EN, MATCH_A_FLAG, MATCH_P_FLAG;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, a;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d, r;
  logic [3:0]  S_AXI_WSTRB, strb;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY, ext_on;
  logic [9:0]  c, c2;
  int          error_cnt, comparisons, seed, cyc, i, hi;
  int          pw_a [7] = '{3, 9, 3, 3, 3, 3, 8};
  int          pw_pa [7] = '{2, 2, 2, 2, 0, 1, 2};
  int          pw_in [7] = '{1, 1, 0, 1, 1, 1, 1};
  int          pw_iv [7] = '{0, 0, 0, 1, 0, 0, 0};
  ptm_timer uut (.CORE_CLK(CORE_CLK), .RST(RST), .HIGH_CLK_TICK(HIGH_CLK_TICK),
    .SUB_CLK(SUB_CLK), .EXT_CLK_PIN(EXT_CLK_PIN), .TIMER_OUT(TIMER_OUT),
    .TIMER_OUT_EN(TIMER_OUT_EN), .MATCH_A_FLAG(MATCH_A_FLAG), .MATCH_P_FLAG(MATCH_P_FLAG),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // Sub clock and trigger pin as slow square waves
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    HIGH_CLK_TICK <= 1'($random(seed));
    SUB_CLK <= cyc[3];
    EXT_CLK_PIN <= ext_on & cyc[2];
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tmo();
    chk(32'h0000_0000, 32'h0000_0001);
    summarize();
  endtask : tmo
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= dt;
    S_AXI_WSTRB <= strb;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) break;
    end
    S_AXI_BREADY <= 1'b0;
    if (n == 64) tmo();
    chk(S_AXI_BRESP, er);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= ad;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    dt = S_AXI_RDATA;
    S_AXI_RREADY <= 1'b0;
    if (n == 64) tmo();
    chk(S_AXI_RRESP, er);
  endtask : rd
  task automatic cfg(input logic [1:0] md, input logic [1:0] pa, input logic ini,
                     input logic iv, input logic clr, input logic [9:0] va, input logic [9:0] vp);
    wr(CTRL0_OFF, 32'h0000_0000, RESP_OKAY);
    wr(CTRL1_OFF, {24'h00_0000, md, pa, ini, iv, 1'b0, clr}, RESP_OKAY);
    wr(CMPA_LO_OFF, {24'h00_0000, va[7:0]}, RESP_OKAY);
    wr(CMPA_HI_OFF, {30'h0000_0000, va[9:8]}, RESP_OKAY);
    wr(PER_LO_OFF, {24'h00_0000, vp[7:0]}, RESP_OKAY);
    wr(PER_HI_OFF, {30'h0000_0000, vp[9:8]}, RESP_OKAY);
    wr(FLAGS_OFF, 32'h0000_0003, RESP_OKAY);
  endtask : cfg
  task automatic go(input logic [2:0] ck);
    wr(CTRL0_OFF, {24'h00_0000, 1'b0, ck, 1'b1, 3'b000}, RESP_OKAY);
  endtask : go
  task automatic wait_flag(input logic wp, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge CORE_CLK);
      if ((wp ? MATCH_P_FLAG : MATCH_A_FLAG) === 1'b1) break;
    end
    if (n == lim) tmo();
    comparisons++;
  endtask : wait_flag
  task automatic rdcnt(output logic [9:0] cv);
    logic [31:0] lo, hb;
    rd(CNT_LO_OFF, lo, RESP_OKAY);
    rd(CNT_HI_OFF, hb, RESP_OKAY);
    chk(hb[31:2], 30'h0000_0000);
    cv = {hb[1:0], lo[7:0]};
  endtask : rdcnt
  function automatic logic exp_pin(input logic [1:0] pa, input logic ini);
    return (pa == PACT_NONE) ? ini : (pa != PACT_LOW);
  endfunction : exp_pin
  function automatic int exp_pwm(input int va, input int vp, input int pa, input int ini,
                                 input int iv);
    int act, h;
    act = (pa == 2) ? ((va >= vp) ? vp : va) * 10 : ((pa == 1) ? 80 : 0);
    h = ini ? act : 80 - act;
    return iv ? 80 - h : h;
  endfunction : exp_pwm
  function automatic logic [31:0] exp_reg(input logic [7:0] ad, input logic [31:0] dt);
    return ad[2] ? (dt & 32'h0000_0003) : (dt & 32'h0000_00FF);
  endfunction : exp_reg
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hf285_cd1d;
    {error_cnt, comparisons, cyc, ext_on, RST, strb} = {96'h0, 1'b0, 1'b1, 4'hF};
    {HIGH_CLK_TICK, SUB_CLK, EXT_CLK_PIN, S_AXI_AWVALID, S_AXI_WVALID} = 5'h00;
    {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = 19'h0_0000;
    {S_AXI_WDATA, S_AXI_WSTRB} = 36'h0_0000_0000;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    for (i = 0; i <= 8; i++) begin
      rd(8'(4 * i), r, RESP_OKAY);
      chk(r, 32'h0000_0000);
    end
    rd(8'h24, r, RESP_SLVERR);
    wr(8'h24, 32'h0000_00FF, RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      a = CMPA_LO_OFF + 8'(4 * (i % 4));
      d = $random(seed);
      wr(a, d, RESP_OKAY);
      strb = 4'hE;
      wr(a, ~d, RESP_OKAY);
      strb = 4'hF;
      rd(a, r, RESP_OKAY);
      chk(r, exp_reg(a, d));
    end
    for (i = 0; i < 4; i++) begin
      cfg(MODE_CMP, 2'(i), i == 1, 1'b0, 1'b0, 10'd40, 10'd60);
      go(CK_SYS);
      repeat (3) @(posedge CORE_CLK);
      chk(TIMER_OUT, i == 1);
      chk(TIMER_OUT_EN, 1'b1);
      wait_flag(1'b0, 200);
      repeat (2) @(posedge CORE_CLK);
      chk(TIMER_OUT, exp_pin(2'(i), i == 1));
      wait_flag(1'b1, 200);
      chk(TIMER_OUT, exp_pin(2'(i), i == 1));
    end
    cfg(MODE_CMP, PACT_NONE, 1'b0, 1'b0, 1'b1, 10'd8, 10'd3);
    go(CK_SYS);
    wait_flag(1'b0, 100);
    repeat (40) @(posedge CORE_CLK);
    chk(MATCH_P_FLAG, 1'b0);
    rdcnt(c);
    chk(c < 10'd8, 1'b1);
    cfg(MODE_TC, PACT_NONE, 1'b0, 1'b0, 1'b0, 10'd0, 10'd0);
    go(CK_SYS);
    chk(TIMER_OUT_EN, 1'b0);
    wait_flag(1'b1, 1100);
    chk(MATCH_A_FLAG, 1'b0);
    wr(CTRL0_OFF, 32'h0000_0098, RESP_OKAY);
    rdcnt(c);
    repeat (20) @(posedge CORE_CLK);
    rdcnt(c2);
    chk(c2, c);
    wr(CTRL0_OFF, 32'h0000_0018, RESP_OKAY);
    rdcnt(c2);
    chk(c2 > c, 1'b1);
    repeat (30) @(posedge CORE_CLK);
    wr(CTRL0_OFF, 32'h0000_0010, RESP_OKAY);
    rdcnt(c);
    repeat (20) @(posedge CORE_CLK);
    rdcnt(c2);
    chk(c2, c);
    go(CK_SYS);
    rdcnt(c2);
    chk(c2 < 10'd16, 1'b1);
    for (i = 0; i < 7; i++) begin
      cfg(MODE_PWM, 2'(pw_pa[i]), 1'(pw_in[i]), 1'(pw_iv[i]), i == 6, 10'(pw_a[i]), 10'd8);
      go(CK_SYS);
      repeat (20) @(posedge CORE_CLK);
      hi = 0;
      repeat (80) begin
        @(posedge CORE_CLK);
        if (TIMER_OUT === 1'b1) hi++;
      end
      chk(hi, exp_pwm(pw_a[i], 8, pw_pa[i], pw_in[i], pw_iv[i]));
      // Duty beyond the period never meets the counter, so no A match then
      chk(MATCH_A_FLAG, pw_a[i] <= 8);
      chk(MATCH_P_FLAG, 1'b1);
    end
    cfg(MODE_PWM, PACT_TOG, 1'b1, 1'b0, 1'b1, 10'd30, 10'd5);
    go(CK_SYS);
    repeat (2) @(posedge CORE_CLK);
    chk(TIMER_OUT, 1'b1);
    wait_flag(1'b0, 100);
    repeat (2) @(posedge CORE_CLK);
    chk(TIMER_OUT, 1'b0);
    rd(CTRL0_OFF, r, RESP_OKAY);
    chk(r[RUN_BIT], 1'b0);
    cfg(MODE_PWM, PACT_TOG, 1'b1, 1'b0, 1'b0, 10'd3, 10'd5);
    wr(CTRL0_OFF, {24'h00_0000, 1'b0, CK_EXTR, 4'h0}, RESP_OKAY);
    ext_on <= 1'b1;
    wait_flag(1'b0, 300);
    for (i = 0; i < 8; i++) begin
      cfg(MODE_TC, PACT_NONE, 1'b0, 1'b0, 1'b0, 10'd0, 10'd0);
      go(3'(i));
      repeat (600) @(posedge CORE_CLK);
      rdcnt(c);
      chk(c != 10'd0, 1'b1);
    end
    // Mode 01 is outside the covered modes and must release the pin
    cfg(2'b01, PACT_NONE, 1'b1, 1'b0, 1'b0, 10'd0, 10'd0);
    chk(TIMER_OUT_EN, 1'b0);
    summarize();
  end
endmodule : tb_top
bind ptm_timer pt_checker chk_i (.CORE_CLK(CORE_CLK), .RST(RST), .MATCH_A_FLAG(MATCH_A_FLAG),
  .MATCH_P_FLAG(MATCH_P_FLAG), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
